// [common/cba_defines.vh]
// constants for the condition, branch and alu core
`ifndef CBA_DEFINES_VH
`define CBA_DEFINES_VH
// register byte offsets
`define CBA_OFF_CTRL 8'h00
`define CBA_OFF_TPTR 8'h04
`define CBA_OFF_LINK 8'h08
`define CBA_OFF_SIPC 8'h0C
`define CBA_OFF_CNTA 8'h10
`define CBA_OFF_CNTB 8'h14
`define CBA_OFF_A0LO 8'h18
`define CBA_OFF_A0HI 8'h1C
`define CBA_OFF_A1LO 8'h20
`define CBA_OFF_A1HI 8'h24
`define CBA_OFF_STAT 8'h28
`define CBA_OFF_WAIT 8'h2C
// ctrl register field
`define CBA_CTRL_NOISE_INHIBIT 0
// noise reset value and emulator call vector
`define CBA_NOISE_SEED 10'h3FF
`define CBA_EMU_VECTOR 16'h0000
// cycle counts
`define CBA_CYC_UNCOND 4'h2
`define CBA_CYC_EMU 4'h3
`define CBA_CYC_COND 4'h3
`define CBA_CYC_ALU_IMM 4'h2
// control operations
`define CBA_CTL_GOTO_ABS 3'h0
`define CBA_CTL_GOTO_PTR 3'h1
`define CBA_CTL_CALL_ABS 3'h2
`define CBA_CTL_CALL_PTR 3'h3
`define CBA_CTL_EMU_CALL 3'h4
`define CBA_CTL_RETURN 3'h5
`define CBA_CTL_IRETURN 3'h6
// alu operations
`define CBA_ALU_ADD 3'h0
`define CBA_ALU_SUB 3'h1
`define CBA_ALU_AND 3'h2
`define CBA_ALU_OR 3'h3
`define CBA_ALU_XOR 3'h4
`define CBA_ALU_CMP 3'h5
`define CBA_ALU_TST 3'h6
// alu second operand source
`define CBA_SRC_ACC 2'h0
`define CBA_SRC_PROD 2'h1
`define CBA_SRC_IMM_HI 2'h2
`define CBA_SRC_IMM_LO 2'h3
// branch test codes
`define CBA_TC_NONNEG 5'h00
`define CBA_TC_NEG 5'h01
`define CBA_TC_ZERO 5'h02
`define CBA_TC_NONZERO 5'h03
`define CBA_TC_POS 5'h04
`define CBA_TC_NOTPOS 5'h05
`define CBA_TC_WOVF_SET 5'h06
`define CBA_TC_WOVF_CLR 5'h07
`define CBA_TC_NOVF_SET 5'h08
`define CBA_TC_NOVF_CLR 5'h09
`define CBA_TC_CNTA_GE 5'h0A
`define CBA_TC_CNTA_LT 5'h0B
`define CBA_TC_CNTB_GE 5'h0C
`define CBA_TC_CNTB_LT 5'h0D
`define CBA_TC_NOISE_SET 5'h0E
`define CBA_TC_NOISE_CLR 5'h0F
`define CBA_TC_TRUE 5'h10
`define CBA_TC_FALSE 5'h11
`define CBA_TC_BIT_ALL 5'h12
`define CBA_TC_BIT_NONE 5'h13
`define CBA_TC_BIT_SOME 5'h14
`define CBA_TC_BIT_SOMEF 5'h15
`define CBA_TC_ODD_PAR 5'h16
`define CBA_TC_EVEN_PAR 5'h17
`define CBA_TC_MINUS1 5'h18
`define CBA_TC_NMINUS1 5'h19
`define CBA_TC_NPINT 5'h1A
`define CBA_TC_NJINT 5'h1B
`define CBA_TC_LOCK 5'h1C
`endif

// [dv/cba_core_bench.sv]
// self-checking bench for the condition, branch and alu core
`include "cba_defines.vh"
module cba_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = '0;
	logic sys_rst = '1;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0;
	logic [31:0] s_axi_wdata = '0, product_in = 32'h8000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic ctl_valid = '0, ctl_guarded = '0, alu_valid = '0;
	logic alu_sel_s = '0, alu_sel_t = '0, alu_sel_d = '0;
	logic from_cache = '0, in_isr = '0, pc_external = '0, tptr_external = '0, link_external = '0;
	logic [2:0] ctl_op = '0, alu_op = '0;
	logic [1:0] alu_src = '0, rr;
	logic [4:0] branch_test_code = '0;
	logic [11:0] jump_field = 12'h345;
	// op sits at the last word of a page, so the incremented pc is already in the next
	logic [15:0] imm_operand = '0, pc_incr = 16'h2000, tg;
	logic [10:0] flag_set = '0;
	logic [15:0] tgt [7] = '{16'h2345, 16'h0ABC, 16'h2345, 16'h0ABC, `CBA_EMU_VECTOR,
		16'h2000, 16'h2000};
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire op_ready, op_refused, pc_load, branch_taken;
	wire [15:0] pc_target;
	wire bit_all_match, bit_none_match, bit_some_match, bit_some_fail, dev_pint, dev_jint;
	wire bmf_odd_parity, bmf_even_parity, bmf_minus_one, bmf_not_minus_one, pll_locked_pin;
	int n_fail = 0, checked = 0, cyc = 0, n, i, k;
	logic tk, rf;
	logic [31:0] rd;
	logic [9:0] g;
	cba_core i_cba_core (.*);
	cba_flag_src i_cba_flag_src (.*);
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			conclude;
		end
	end
	task conclude;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		checked++;
		if (v !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, v);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		rr = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task rdr(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	// counts edges until the core is ready again, noting pulses on the way
	task wt;
		n = 0;
		tk = 0;
		rf = 0;
		do begin
			@(posedge clk_sys);
			n++;
			tk |= pc_load & branch_taken;
			rf |= op_refused;
		end while (op_ready !== 1'b1);
		tg = pc_target;
	endtask
	task op(input logic [2:0] o, input logic gd, input logic [4:0] c);
		@(posedge clk_sys);
		ctl_op <= o;
		ctl_guarded <= gd;
		branch_test_code <= c;
		ctl_valid <= 1;
		do @(posedge clk_sys); while (op_ready !== 1'b1);
		ctl_valid <= 0;
		wt;
	endtask
	task al(input logic [2:0] o, input logic [1:0] s, input logic a, b, d, input logic [15:0] im);
		@(posedge clk_sys);
		alu_op <= o;
		alu_src <= s;
		alu_sel_s <= a;
		alu_sel_t <= b;
		alu_sel_d <= d;
		imm_operand <= im;
		alu_valid <= 1;
		do @(posedge clk_sys); while (op_ready !== 1'b1);
		alu_valid <= 0;
		wt;
	endtask
	task tc(input logic [4:0] c, input logic e);
		op(`CBA_CTL_GOTO_ABS, 1, c);
		chk("guard cycles", 3, n);
		chk("taken", e, tk);
	endtask
	// bit c of e is the expected outcome of sign and overflow test code c
	task step(input logic [2:0] o, input logic [1:0] s, input logic a, b, d,
		input logic [15:0] im, input logic [9:0] e);
		al(o, s, a, b, d, im);
		chk("alu cycles", s[1] ? 2 : 1, n);
		for (k = 0; k < 10; k++) tc(k[4:0], e[k]);
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		sys_rst <= 0;
		rdr(`CBA_OFF_STAT);
		chk("noise seed", `CBA_NOISE_SEED, rd[21:12]);
		rdr(8'h30);
		chk("unmapped rdata", 0, rd);
		chk("unmapped rresp", 2'b10, rr);
		wr(8'h30, 0);
		chk("unmapped bresp", 2'b10, rr);
		$display("done: reset");
		wr(`CBA_OFF_TPTR, 32'h0000_0ABC);
		chk("bresp", 0, rr);
		for (i = 0; i < 7; i++) begin
			op(i[2:0], 0, 0);
			chk("uncond cycles", i == 4 ? 3 : 2, n);
			chk("uncond target", tgt[i], tg);
			chk("uncond pulse", 1, tk);
		end
		for (i = 0; i < 6; i++) if (i != 4) begin
			op(i[2:0], 1, `CBA_TC_FALSE);
			chk("false skipped", 0, tk);
			chk("false cycles", 3, n);
			op(i[2:0], 1, `CBA_TC_TRUE);
			chk("true taken", 1, tk);
		end
		$display("done: control");
		wr(`CBA_OFF_WAIT, 32'h0000_0002);
		pc_external <= 1;
		op(`CBA_CTL_GOTO_ABS, 0, 0);
		chk("pc wait cycles", 4, n);
		pc_external <= 0;
		tptr_external <= 1;
		op(`CBA_CTL_GOTO_PTR, 0, 0);
		chk("pointer wait cycles", 4, n);
		link_external <= 1;
		op(`CBA_CTL_RETURN, 0, 0);
		chk("link wait cycles", 4, n);
		{tptr_external, link_external} <= 2'b00;
		wr(`CBA_OFF_WAIT, 0);
		for (i = 0; i < 3; i++) begin
			op(i == 0 ? 3'h4 : i == 1 ? 3'h6 : 3'h7, 1, `CBA_TC_TRUE);
			chk("guard refused", 1, rf);
			chk("refused no jump", 0, tk);
		end
		from_cache <= 1;
		op(`CBA_CTL_GOTO_ABS, 0, 0);
		chk("cache refused", 1, rf);
		chk("cache no jump", 0, tk);
		al(`CBA_ALU_ADD, `CBA_SRC_IMM_HI, 0, 0, 0, 16'h0000);
		chk("cache imm refused", 1, rf);
		from_cache <= 0;
		$display("done: refusal");
		step(`CBA_ALU_ADD, `CBA_SRC_IMM_HI, 0, 0, 0, 16'h8000, 10'h2AA);
		step(`CBA_ALU_ADD, `CBA_SRC_ACC, 0, 0, 0, 16'h0000, 10'h1AA);
		step(`CBA_ALU_CMP, `CBA_SRC_ACC, 0, 0, 0, 16'h0000, 10'h2A5);
		step(`CBA_ALU_ADD, `CBA_SRC_ACC, 0, 1, 1, 16'h0000, 10'h1AA);
		step(`CBA_ALU_ADD, `CBA_SRC_PROD, 1, 0, 1, 16'h0000, 10'h1AA);
		step(`CBA_ALU_ADD, `CBA_SRC_IMM_LO, 0, 0, 0, 16'h0001, 10'h1AA);
		step(`CBA_ALU_TST, `CBA_SRC_IMM_HI, 0, 0, 0, 16'h0000, 10'h299);
		$display("done: alu");
		for (i = 0; i < 11; i++) begin
			flag_set <= 11'h001 << i;
			repeat (4) @(posedge clk_sys);
			k = i < 8 ? `CBA_TC_BIT_ALL + i : i == 8 ? `CBA_TC_LOCK : `CBA_TC_NPINT + i - 9;
			tc(k[4:0], i < 9);
			flag_set <= '0;
			repeat (4) @(posedge clk_sys);
			tc(k[4:0], i >= 9);
		end
		for (i = 0; i < 2; i++) begin
			k = `CBA_TC_CNTA_GE + 2 * i;
			tc(k[4:0], 1);
			rdr(`CBA_OFF_CNTA + 8'(4 * i));
			chk("counter step", 1, rd[15:0]);
			wr(`CBA_OFF_CNTA + 8'(4 * i), 32'h0000_FFFF);
			tc(k[4:0] + 5'h01, 1);
			rdr(`CBA_OFF_CNTA + 8'(4 * i));
			chk("counter wrap", 0, rd[15:0]);
		end
		$display("done: flags");
		g = `CBA_NOISE_SEED;
		for (i = 0; i < 14; i++) begin
			tc(`CBA_TC_NOISE_SET + 5'(i % 2), g[0] ^ i[0]);
			g = {g[0] ^ g[3], g[9:1]};
		end
		rdr(`CBA_OFF_STAT);
		chk("noise state", g, rd[21:12]);
		in_isr <= 1;
		wr(`CBA_OFF_SIPC, 32'h0000_0055);
		rdr(`CBA_OFF_STAT);
		chk("isr write keeps noise", g, rd[21:12]);
		in_isr <= 0;
		wr(`CBA_OFF_CTRL, 32'h0000_0001);
		wr(`CBA_OFF_SIPC, 32'h0000_0055);
		rdr(`CBA_OFF_STAT);
		chk("inhibited write keeps noise", g, rd[21:12]);
		wr(`CBA_OFF_CTRL, 0);
		wr(`CBA_OFF_SIPC, 32'h0000_0055);
		rdr(`CBA_OFF_STAT);
		chk("write resets noise", `CBA_NOISE_SEED, rd[21:12]);
		rdr(`CBA_OFF_SIPC);
		chk("saved pc written", 16'h0055, rd[15:0]);
		al(`CBA_ALU_OR, `CBA_SRC_ACC, 1, 1, 1, 16'h0000);
		rdr(`CBA_OFF_SIPC);
		chk("saved pc overwritten", 16'h2000, rd[15:0]);
		$display("done: noise");
		conclude;
	end
endmodule

// [dv/cba_core_properties.sv]
// concurrent checks on control timing, refusals and alu busy time
`include "cba_defines.vh"
module cba_core_properties (
	// clock and reset
	input logic clk_sys,
	input logic sys_rst,
	// control request
	input logic ctl_valid,
	input logic [2:0] ctl_op,
	input logic ctl_guarded,
	input logic [4:0] branch_test_code,
	input logic [11:0] jump_field,
	input logic [15:0] pc_incr,
	// alu request
	input logic alu_valid,
	input logic [1:0] alu_src,
	// context
	input logic from_cache,
	input logic pc_external,
	input logic tptr_external,
	input logic link_external,
	// answers
	input logic op_ready,
	input logic op_refused,
	input logic pc_load,
	input logic [15:0] pc_target,
	input logic branch_taken
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// accepted control op with internal memory only, so no wait states apply
	wire ext = pc_external || tptr_external || link_external;
	wire go = ctl_valid && op_ready && !from_cache && !ext;
	wire gok = ctl_guarded && ctl_op != 3'h4 && ctl_op != 3'h6 && ctl_op != 3'h7;
	wire al = alu_valid && op_ready && !ctl_valid && !from_cache;
	sequence s_busy1;
		!op_ready ##1 op_ready;
	endsequence
	sequence s_busy2;
		!op_ready [*2] ##1 op_ready;
	endsequence
	property p_abs;
		logic [3:0] pg;
		logic [11:0] jf;
		(go && !ctl_guarded && (ctl_op == `CBA_CTL_GOTO_ABS || ctl_op == `CBA_CTL_CALL_ABS),
			pg = pc_incr[15:12], jf = jump_field) |-> ##2 pc_load && pc_target == {pg, jf};
	endproperty
	a_uncond_two: assert property (go && !ctl_guarded && ctl_op != 3'h4 && ctl_op != 3'h7
		|=> s_busy1) else $error("unconditional op busy time wrong");
	a_emu_three: assert property (go && !ctl_guarded && ctl_op == 3'h4 |=> s_busy2)
		else $error("emulator call busy time wrong");
	a_guard_three: assert property (go && gok |=> s_busy2)
		else $error("guarded op busy time wrong");
	a_cache_refuse: assert property (ctl_valid && op_ready && from_cache |=> op_refused)
		else $error("cached control op not refused");
	a_guard_refuse: assert property (ctl_valid && op_ready && ctl_guarded
		&& (ctl_op == 3'h4 || ctl_op == 3'h6) |=> op_refused) else $error("guarded op not refused");
	a_abs_page: assert property (p_abs)
		else $error("absolute target wrong");
	a_true_taken: assert property (go && gok && branch_test_code == `CBA_TC_TRUE
		|-> ##3 pc_load && branch_taken) else $error("true test did not branch");
	a_false_never: assert property (go && gok && branch_test_code == `CBA_TC_FALSE
		|=> !pc_load [*3]) else $error("false test branched");
	a_imm_two: assert property (al && alu_src[1] |=> s_busy1)
		else $error("immediate alu busy time wrong");
	a_reg_one: assert property (al && !alu_src[1] |=> op_ready)
		else $error("register alu busy time wrong");
endmodule
bind cba_core cba_core_properties i_cba_core_properties (.*);

// [dv/cba_flag_src.sv]
// flag source model: bit-io match results, bit-manipulation flags, pll lock, debug interrupts
module cba_flag_src (
	// clock and request
	input logic clk_sys,
	input logic [10:0] flag_set,
	// flag outputs
	output logic bit_all_match,
	output logic bit_none_match,
	output logic bit_some_match,
	output logic bit_some_fail,
	output logic bmf_odd_parity,
	output logic bmf_even_parity,
	output logic bmf_minus_one,
	output logic bmf_not_minus_one,
	output logic dev_pint,
	output logic dev_jint,
	output logic pll_locked_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge clk_sys) begin
		{bit_some_fail, bit_some_match, bit_none_match, bit_all_match} <= flag_set[3:0];
		{bmf_not_minus_one, bmf_minus_one} <= flag_set[7:6];
		{bmf_even_parity, bmf_odd_parity} <= flag_set[5:4];
		{dev_jint, dev_pint} <= flag_set[10:9];
	end
	// lock comes from another clock, so it moves away from the core edge
	always @(negedge clk_sys) pll_locked_pin <= flag_set[8];
endmodule

// [hdl/cba_core.v]
// condition evaluation, control transfer timing and 36-bit two-operand alu
// Behaviour
// - unconditional control two cycles, emulator call three
// - guarded control always three cycles, two words
// - add wait states for external pc, pointer, link
// - control ops never run from loop cache
// - interrupt return, emulator call never guarded
// - absolute target: 12-bit field within page
// - page bits from incremented program counter
// - sign tests use result bit 35
// - wide overflow flag: 36-bit unrepresentable
// - narrow overflow: bits 35..31 disagree
// - counter tests compare zero, then increment
// - noise bit from ten-stage generator, advances
// - saved pc write outside isr resets generator
// - inhibit bit blocks generator reset
// - saved pc overwritten by next pc
// - bit-io tests report four match outcomes
// - parity, minus-one tests use bit-manip flags
// - lock test needs stable pll lock
// - full 36-bit alu, product sign-extended
// - high immediate sign-extended, low zeros/ones
// - register alu one cycle, immediate two
// - compare and test only update flags
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`include "cba_defines.vh"
module cba_core (
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// axi4-lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// sequencer: control operation
	input wire ctl_valid,
	input wire [2:0] ctl_op,
	input wire ctl_guarded,
	input wire [4:0] branch_test_code,
	input wire [11:0] jump_field,
	// sequencer: alu operation
	input wire alu_valid,
	input wire [2:0] alu_op,
	input wire [1:0] alu_src,
	input wire alu_sel_s,
	input wire alu_sel_t,
	input wire alu_sel_d,
	input wire [15:0] imm_operand,
	input wire [31:0] product_in,
	// sequencer: context
	input wire [15:0] pc_incr,
	input wire from_cache,
	input wire in_isr,
	input wire pc_external,
	input wire tptr_external,
	input wire link_external,
	output wire op_ready,
	output reg op_refused,
	output reg pc_load,
	output reg [15:0] pc_target,
	output reg branch_taken,
	// flag sources
	input wire bit_all_match,
	input wire bit_none_match,
	input wire bit_some_match,
	input wire bit_some_fail,
	input wire bmf_odd_parity,
	input wire bmf_even_parity,
	input wire bmf_minus_one,
	input wire bmf_not_minus_one,
	input wire dev_pint,
	input wire dev_jint,
	input wire pll_locked_pin
);

reg ctrl_reg;
reg [15:0] table_pointer_reg;
reg [15:0] subroutine_link_reg;
reg [15:0] saved_interrupt_pc_reg;
reg [15:0] event_counter_a;
reg [15:0] event_counter_b;
reg [35:0] acc0_reg;
reg [35:0] acc1_reg;
reg [3:0] wait_reg;
reg [9:0] noise_sequence_gen;
reg sipc_pending_reg;
reg flag_neg_reg;
reg flag_zero_reg;
reg flag_wovf_reg;
reg flag_novf_reg;
reg [4:0] cnt_reg;
reg [15:0] tgt_reg;
reg tgt_take_reg;
reg lock_s1_reg;
reg lock_s2_reg;
reg aw_full_reg;
reg w_full_reg;
reg [7:0] aw_addr_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;

wire noise_reset_inhibit = ctrl_reg;

// pll lock comes from another clock domain
always @(posedge clk_sys) begin
	if (sys_rst) begin
		lock_s1_reg <= 1'b0;
		lock_s2_reg <= 1'b0;
	end else begin
		lock_s1_reg <= pll_locked_pin;
		lock_s2_reg <= lock_s1_reg;
	end
end

assign op_ready = (cnt_reg == 5'h00);
wire ctl_go = ctl_valid && op_ready;
wire alu_go = alu_valid && op_ready && !ctl_valid;

// test code evaluation
wire result_negative = flag_neg_reg;
wire result_nonnegative = !flag_neg_reg;
wire result_zero = flag_zero_reg;
wire result_nonzero = !flag_zero_reg;
wire result_positive = !flag_neg_reg && !flag_zero_reg;
wire result_not_positive = flag_neg_reg || flag_zero_reg;
wire counter_a_nonneg = !event_counter_a[15];
wire counter_a_negative = event_counter_a[15];
wire counter_b_nonneg = !event_counter_b[15];
wire counter_b_negative = event_counter_b[15];
wire noise_bit = noise_sequence_gen[0];
reg cond_true;
always @* begin
	case (branch_test_code)
	`CBA_TC_NONNEG: cond_true = result_nonnegative;
	`CBA_TC_NEG: cond_true = result_negative;
	`CBA_TC_ZERO: cond_true = result_zero;
	`CBA_TC_NONZERO: cond_true = result_nonzero;
	`CBA_TC_POS: cond_true = result_positive;
	`CBA_TC_NOTPOS: cond_true = result_not_positive;
	`CBA_TC_WOVF_SET: cond_true = flag_wovf_reg;
	`CBA_TC_WOVF_CLR: cond_true = !flag_wovf_reg;
	`CBA_TC_NOVF_SET: cond_true = flag_novf_reg;
	`CBA_TC_NOVF_CLR: cond_true = !flag_novf_reg;
	`CBA_TC_CNTA_GE: cond_true = counter_a_nonneg;
	`CBA_TC_CNTA_LT: cond_true = counter_a_negative;
	`CBA_TC_CNTB_GE: cond_true = counter_b_nonneg;
	`CBA_TC_CNTB_LT: cond_true = counter_b_negative;
	`CBA_TC_NOISE_SET: cond_true = noise_bit;
	`CBA_TC_NOISE_CLR: cond_true = !noise_bit;
	`CBA_TC_TRUE: cond_true = 1'b1;
	`CBA_TC_FALSE: cond_true = 1'b0;
	`CBA_TC_BIT_ALL: cond_true = bit_all_match;
	`CBA_TC_BIT_NONE: cond_true = bit_none_match;
	`CBA_TC_BIT_SOME: cond_true = bit_some_match;
	`CBA_TC_BIT_SOMEF: cond_true = bit_some_fail;
	`CBA_TC_ODD_PAR: cond_true = bmf_odd_parity;
	`CBA_TC_EVEN_PAR: cond_true = bmf_even_parity;
	`CBA_TC_MINUS1: cond_true = bmf_minus_one;
	`CBA_TC_NMINUS1: cond_true = bmf_not_minus_one;
	`CBA_TC_NPINT: cond_true = !dev_pint;
	`CBA_TC_NJINT: cond_true = !dev_jint;
	`CBA_TC_LOCK: cond_true = lock_s2_reg;
	default: cond_true = 1'b0;
	endcase
end

// control operation decode
wire ctl_bad_guard = ctl_guarded &&
	(ctl_op == `CBA_CTL_EMU_CALL || ctl_op == `CBA_CTL_IRETURN);
wire ctl_bad_op = (ctl_op == 3'h7);
wire ctl_reject = from_cache || ctl_bad_guard || ctl_bad_op;
wire ctl_accept = ctl_go && !ctl_reject;
wire take = !ctl_guarded || cond_true;
wire [15:0] abs_target = {pc_incr[15:12], jump_field};
reg [15:0] target;
reg target_ext;
always @* begin
	target = abs_target;
	target_ext = 1'b0;
	case (ctl_op)
	`CBA_CTL_GOTO_PTR, `CBA_CTL_CALL_PTR: begin
		target = table_pointer_reg;
		target_ext = tptr_external;
	end
	`CBA_CTL_EMU_CALL: target = `CBA_EMU_VECTOR;
	`CBA_CTL_RETURN: begin
		target = subroutine_link_reg;
		target_ext = link_external;
	end
	`CBA_CTL_IRETURN: target = saved_interrupt_pc_reg;
	default: target = abs_target;
	endcase
end
wire [3:0] base_cyc = ctl_guarded ? `CBA_CYC_COND :
	(ctl_op == `CBA_CTL_EMU_CALL) ? `CBA_CYC_EMU : `CBA_CYC_UNCOND;
wire [3:0] add_ws = (pc_external || target_ext) ? wait_reg : 4'h0;
wire [4:0] ctl_cyc = {1'b0, base_cyc} + {1'b0, add_ws};
wire tests_cnt_a = ctl_accept && ctl_guarded &&
	(branch_test_code == `CBA_TC_CNTA_GE || branch_test_code == `CBA_TC_CNTA_LT);
wire tests_cnt_b = ctl_accept && ctl_guarded &&
	(branch_test_code == `CBA_TC_CNTB_GE || branch_test_code == `CBA_TC_CNTB_LT);
wire tests_noise = ctl_accept && ctl_guarded &&
	(branch_test_code == `CBA_TC_NOISE_SET || branch_test_code == `CBA_TC_NOISE_CLR);

// alu datapath
wire alu_imm = alu_src[1];
wire alu_reject = alu_imm && from_cache;
wire alu_accept = alu_go && !alu_reject;
wire [35:0] opa_full = alu_sel_s ? acc1_reg : acc0_reg;
reg [35:0] opb;
always @* begin
	case (alu_src)
	`CBA_SRC_ACC: opb = alu_sel_t ? acc1_reg : acc0_reg;
	`CBA_SRC_PROD: opb = {{4{product_in[31]}}, product_in};
	`CBA_SRC_IMM_HI: opb = (alu_op == `CBA_ALU_AND || alu_op == `CBA_ALU_TST) ?
		{{4{imm_operand[15]}}, imm_operand, 16'hFFFF} :
		{{4{imm_operand[15]}}, imm_operand, 16'h0000};
	`CBA_SRC_IMM_LO: opb = (alu_op == `CBA_ALU_AND || alu_op == `CBA_ALU_TST) ?
		{20'hF_FFFF, imm_operand} : {20'h0_0000, imm_operand};
	default: opb = 36'h0_0000_0000;
	endcase
end
wire [36:0] ext_a = {opa_full[35], opa_full};
wire [36:0] ext_b = {opb[35], opb};
reg [36:0] wide;
always @* begin
	case (alu_op)
	`CBA_ALU_ADD: wide = ext_a + ext_b;
	`CBA_ALU_SUB, `CBA_ALU_CMP: wide = ext_a - ext_b;
	`CBA_ALU_AND, `CBA_ALU_TST: wide = ext_a & ext_b;
	`CBA_ALU_OR: wide = ext_a | ext_b;
	`CBA_ALU_XOR: wide = ext_a ^ ext_b;
	default: wide = 37'h0_0000_0000;
	endcase
end
wire [35:0] alu_res = wide[35:0];
wire alu_wovf = wide[36] ^ wide[35];
wire alu_novf = !(&alu_res[35:31]) && (|alu_res[35:31]);
wire alu_writes = alu_op != `CBA_ALU_CMP && alu_op != `CBA_ALU_TST;

// axi4-lite write side
assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
wire wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
	{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
wire [31:0] wd = w_data_reg & wmask;
reg wr_hit;
always @* begin
	case (aw_addr_reg)
	`CBA_OFF_CTRL, `CBA_OFF_TPTR, `CBA_OFF_LINK, `CBA_OFF_SIPC, `CBA_OFF_CNTA,
	`CBA_OFF_CNTB, `CBA_OFF_A0LO, `CBA_OFF_A0HI, `CBA_OFF_A1LO, `CBA_OFF_A1HI,
	`CBA_OFF_WAIT: wr_hit = 1'b1;
	default: wr_hit = 1'b0;
	endcase
end
wire wr_sel_sipc = wr_fire && aw_addr_reg == `CBA_OFF_SIPC && w_strb_reg[1:0] != 2'b00;
wire noise_clear = wr_sel_sipc && !in_isr && !noise_reset_inhibit;
// byte lane merge for a 16-bit register
function [15:0] merge16;
	input [15:0] old;
	input [31:0] d;
	input [3:0] s;
	begin
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	end
endfunction

always @(posedge clk_sys) begin
	if (sys_rst) begin
		aw_full_reg <= 1'b0;
		w_full_reg <= 1'b0;
		aw_addr_reg <= 8'h00;
		w_data_reg <= 32'h0000_0000;
		w_strb_reg <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'b00;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// architectural state; sequencer updates win over software writes
always @(posedge clk_sys) begin
	if (sys_rst) begin
		ctrl_reg <= 1'b0;
		table_pointer_reg <= 16'h0000;
		subroutine_link_reg <= 16'h0000;
		saved_interrupt_pc_reg <= 16'h0000;
		event_counter_a <= 16'h0000;
		event_counter_b <= 16'h0000;
		acc0_reg <= 36'h0_0000_0000;
		acc1_reg <= 36'h0_0000_0000;
		wait_reg <= 4'h0;
		noise_sequence_gen <= `CBA_NOISE_SEED;
		sipc_pending_reg <= 1'b0;
		flag_neg_reg <= 1'b0;
		flag_zero_reg <= 1'b1;
		flag_wovf_reg <= 1'b0;
		flag_novf_reg <= 1'b0;
	end else begin
		if (wr_fire) begin
			case (aw_addr_reg)
			`CBA_OFF_CTRL: if (w_strb_reg[0])
				ctrl_reg <= w_data_reg[`CBA_CTRL_NOISE_INHIBIT];
			`CBA_OFF_TPTR: table_pointer_reg <= merge16(table_pointer_reg, wd, w_strb_reg);
			`CBA_OFF_LINK: subroutine_link_reg <= merge16(subroutine_link_reg, wd, w_strb_reg);
			`CBA_OFF_SIPC: saved_interrupt_pc_reg <=
				merge16(saved_interrupt_pc_reg, wd, w_strb_reg);
			`CBA_OFF_CNTA: event_counter_a <= merge16(event_counter_a, wd, w_strb_reg);
			`CBA_OFF_CNTB: event_counter_b <= merge16(event_counter_b, wd, w_strb_reg);
			`CBA_OFF_A0LO: acc0_reg[31:0] <= (acc0_reg[31:0] & ~wmask) | wd;
			`CBA_OFF_A0HI: if (w_strb_reg[0]) acc0_reg[35:32] <= w_data_reg[3:0];
			`CBA_OFF_A1LO: acc1_reg[31:0] <= (acc1_reg[31:0] & ~wmask) | wd;
			`CBA_OFF_A1HI: if (w_strb_reg[0]) acc1_reg[35:32] <= w_data_reg[3:0];
			`CBA_OFF_WAIT: if (w_strb_reg[0]) wait_reg <= w_data_reg[3:0];
			default: ctrl_reg <= ctrl_reg;
			endcase
		end
		// outside an isr the saved pc is replaced by the next pc
		if (wr_sel_sipc && !in_isr)
			sipc_pending_reg <= 1'b1;
		else if (sipc_pending_reg && (ctl_go || alu_go)) begin
			sipc_pending_reg <= 1'b0;
			saved_interrupt_pc_reg <= pc_incr;
		end
		if (noise_clear)
			noise_sequence_gen <= `CBA_NOISE_SEED;
		else if (tests_noise)
			noise_sequence_gen <= {noise_sequence_gen[0] ^ noise_sequence_gen[3],
				noise_sequence_gen[9:1]};
		if (tests_cnt_a)
			event_counter_a <= event_counter_a + 16'h0001;
		if (tests_cnt_b)
			event_counter_b <= event_counter_b + 16'h0001;
		if (ctl_accept && take) begin
			if (ctl_op == `CBA_CTL_CALL_ABS || ctl_op == `CBA_CTL_CALL_PTR)
				subroutine_link_reg <= pc_incr;
			if (ctl_op == `CBA_CTL_EMU_CALL)
				saved_interrupt_pc_reg <= pc_incr;
		end
		if (alu_accept) begin
			flag_neg_reg <= alu_res[35];
			flag_zero_reg <= (alu_res == 36'h0_0000_0000);
			flag_wovf_reg <= alu_wovf;
			flag_novf_reg <= alu_novf;
			if (alu_writes && !alu_sel_d)
				acc0_reg <= alu_res;
			if (alu_writes && alu_sel_d)
				acc1_reg <= alu_res;
		end
	end
end

// operation timing and program counter load
always @(posedge clk_sys) begin
	if (sys_rst) begin
		cnt_reg <= 5'h00;
		tgt_reg <= 16'h0000;
		tgt_take_reg <= 1'b0;
		pc_load <= 1'b0;
		pc_target <= 16'h0000;
		branch_taken <= 1'b0;
		op_refused <= 1'b0;
	end else begin
		pc_load <= 1'b0;
		branch_taken <= 1'b0;
		op_refused <= (ctl_go && ctl_reject) || (alu_go && alu_reject);
		if (ctl_accept) begin
			cnt_reg <= ctl_cyc - 5'h01;
			tgt_reg <= target;
			tgt_take_reg <= take;
		end else if (alu_accept && alu_imm) begin
			cnt_reg <= {1'b0, `CBA_CYC_ALU_IMM} - 5'h01;
			tgt_take_reg <= 1'b0;
		end else if (cnt_reg != 5'h00) begin
			cnt_reg <= cnt_reg - 5'h01;
			if (cnt_reg == 5'h01 && tgt_take_reg) begin
				pc_load <= 1'b1;
				pc_target <= tgt_reg;
				branch_taken <= 1'b1;
				tgt_take_reg <= 1'b0;
			end
		end
	end
end

// axi4-lite read side
assign s_axi_arready = !s_axi_rvalid;
always @(posedge clk_sys) begin
	if (sys_rst) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0000_0000;
		s_axi_rresp <= 2'b00;
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rresp <= 2'b00;
		case (s_axi_araddr)
		`CBA_OFF_CTRL: s_axi_rdata <= {31'h0000_0000, ctrl_reg};
		`CBA_OFF_TPTR: s_axi_rdata <= {16'h0000, table_pointer_reg};
		`CBA_OFF_LINK: s_axi_rdata <= {16'h0000, subroutine_link_reg};
		`CBA_OFF_SIPC: s_axi_rdata <= {16'h0000, saved_interrupt_pc_reg};
		`CBA_OFF_CNTA: s_axi_rdata <= {16'h0000, event_counter_a};
		`CBA_OFF_CNTB: s_axi_rdata <= {16'h0000, event_counter_b};
		`CBA_OFF_A0LO: s_axi_rdata <= acc0_reg[31:0];
		`CBA_OFF_A0HI: s_axi_rdata <= {28'h000_0000, acc0_reg[35:32]};
		`CBA_OFF_A1LO: s_axi_rdata <= acc1_reg[31:0];
		`CBA_OFF_A1HI: s_axi_rdata <= {28'h000_0000, acc1_reg[35:32]};
		`CBA_OFF_STAT: s_axi_rdata <= {10'h000, noise_sequence_gen, sipc_pending_reg,
			lock_s2_reg, !op_ready, flag_novf_reg, flag_wovf_reg, flag_zero_reg,
			flag_neg_reg, cnt_reg[3:0], 1'b0};
		`CBA_OFF_WAIT: s_axi_rdata <= {28'h000_0000, wait_reg};
		default: begin
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b10;
		end
		endcase
	end else if (s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
	end
end

endmodule
